/* File: design/ppi_count_rom.sv */
module ppi_count_rom #(
  parameter int PMAX = 8,
  parameter int LMAX = 16,
  parameter int W    = 64,
  parameter int PW   = $clog2(PMAX + 1),
  parameter int LW   = $clog2(LMAX + 1)
) (
  input  wire logic          core_clk_i,
  input  wire logic [PW-1:0] rd_p_i,
  input  wire logic [LW-1:0] rd_len_i,
  output logic      [W-1:0]  rd_data_o
);

  // Splits off one position at a time; values stay exact in W bits
  function automatic logic [W-1:0] f_calc(input int p, input int l);
    logic [W-1:0] col [PMAX+1];
    logic [W-1:0] nxt [PMAX+1];
    begin
      for (int q = 0; q <= PMAX; q++) begin
        col[q] = (q == 0) ? W'(1) : W'(2);
      end
      for (int n = 2; n <= l; n++) begin
        for (int q = 0; q <= PMAX; q++) begin
          nxt[q] = col[q];
          for (int j = 1; j <= q; j++) begin
            nxt[q] = nxt[q] + (col[q-j] << 1);
          end
        end
        for (int q = 0; q <= PMAX; q++) begin
          col[q] = nxt[q];
        end
      end
      f_calc = col[p];
    end
  endfunction : f_calc

  logic [W-1:0] tbl [(PMAX+1)*LMAX];
  int           rd_idx;

  // ----------------------------------------------------------------
  // Constant table of constellation counts
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < (PMAX + 1) * LMAX; gi++) begin : g_ent
    localparam logic [W-1:0] VAL = f_calc(gi / LMAX, gi % LMAX + 1);
    assign tbl[gi] = VAL;
  end

  always_comb begin
    rd_idx = int'(rd_p_i) * LMAX + int'(rd_len_i) - 1;
  end

  always_ff @(posedge core_clk_i) begin
    if (rd_len_i == '0 || int'(rd_len_i) > LMAX || int'(rd_p_i) > PMAX) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= tbl[rd_idx];
    end
  end

endmodule : ppi_count_rom

/* File: design/ppi_defines.svh */
`ifndef PPI_DEFINES_SVH
`define PPI_DEFINES_SVH

// ----------------------------------------------------------------
// Layout widths and lengths
// ----------------------------------------------------------------
`define PPI_M12          5
`define PPI_M20          4
`define PPI_ENUM_LEN     16
`define PPI_MAX_PULSES   8
`define PPI_CNT_W        64
`define PPI_TRK43_LEN    5'h10

// ----------------------------------------------------------------
// Three-pulse track offsets and joint split
// ----------------------------------------------------------------
`define PPI_OFF_N3       13'h0000
`define PPI_OFF_N2       13'h1180
`define PPI_OFF_N1       13'h1540
`define PPI_TRK43_RANGE  13'h1560
`define PPI_JOINT_LIMIT  25'h0371C00

// ----------------------------------------------------------------
// Result field positions
// ----------------------------------------------------------------
`define PPI_F43_IDX1_LSB 25
`define PPI_F43_IDX2_LSB 38

`endif

/* File: design/ppi_pkg.sv */
package ppi_pkg;

  typedef enum logic [2:0] {
    PPI_MODE_12  = 3'h0,
    PPI_MODE_20  = 3'h1,
    PPI_MODE_ENC = 3'h2,
    PPI_MODE_DEC = 3'h3,
    PPI_MODE_43  = 3'h4
  } ppi_mode_t;

  typedef enum logic [5:0] {
    PPI_S_IDLE = 6'h01,
    PPI_S_FIX  = 6'h02,
    PPI_S_POS  = 6'h04,
    PPI_S_TERM = 6'h08,
    PPI_S_ACC  = 6'h10,
    PPI_S_ADV  = 6'h20
  } ppi_state_t;

  typedef struct packed {
    ppi_mode_t       mode;
    logic [5:0][5:0] pos;
    logic [5:0]      neg;
    logic [3:0]      pulses;
    logic [63:0]     data;
  } ppi_req_t;

  typedef struct packed {
    logic [63:0] code;
    logic        long_joint;
    logic        err;
  } ppi_rsp_t;

endpackage : ppi_pkg

/* File: design/ppi_top.sv */
`include "ppi_defines.svh"


module ppi_top #(
  parameter int LEN  = `PPI_ENUM_LEN,
  parameter int PMAX = `PPI_MAX_PULSES
) (
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              start_i,
  input  wire ppi_pkg::ppi_req_t req_i,
  output logic                   done_o,
  output logic                   busy_o,
  output ppi_pkg::ppi_rsp_t      rsp_o
);

  localparam int PW = $clog2(PMAX + 1);
  localparam int LW = $clog2(LEN + 1);
  localparam int IW = $clog2(LEN);
  localparam int CW = `PPI_CNT_W;

  ppi_pkg::ppi_state_t state_r;
  ppi_pkg::ppi_state_t state_nxt;
  ppi_pkg::ppi_req_t   req_r;
  ppi_pkg::ppi_rsp_t   fix_rsp;
  logic [IW-1:0]       idx_r;
  logic [PW-1:0]       rest_r;
  logic [PW-1:0]       k_r;
  // Counts stay within 32 bits, even for the longest track
  // wide state
  logic [CW-1:0]       acc_r;
  logic [CW-1:0]       off_r;
  logic [CW-1:0]       rom_data;
  logic [CW-1:0]       term;
  logic [PW-1:0]       rom_p;
  logic [LW-1:0]       rom_len;
  logic [3:0]          mag_cur;
  logic                neg_cur;
  logic [7:0]          mag_sum;
  logic [LEN-1:0][3:0] dec_vec_r;
  logic                done_r;
  logic                busy_r;
  ppi_pkg::ppi_rsp_t   rsp_r;

  // ----------------------------------------------------------------
  // Small helpers for the three-pulse track index
  // ----------------------------------------------------------------
  function automatic logic [12:0] bin(input logic [4:0] n,
                                      input logic [1:0] k);
    logic [12:0] m;
    begin
      m = {8'h00, n};
      if ({3'h0, k} > n) begin
        bin = 13'h0000;
      end else begin
        case (k)
          2'h0:    bin = 13'h0001;
          2'h1:    bin = m;
          2'h2:    bin = 13'((m * (m - 13'h0001)) >> 1);
          default: bin = 13'((m * (m - 13'h0001) * (m - 13'h0002)) / 6);
        endcase
      end
    end
  endfunction : bin

  // Entry is {position[3:0], negative}; returns {conflict, index}
  function automatic logic [13:0] trk_index(input logic [2:0][4:0] pl);
    logic [4:0]  a, b, c, t;
    logic [1:0]  n;
    logic [3:0]  p0, p1, p2;
    logic [2:0]  sg;
    logic [12:0] i1, i2, i3, cmn, i23;
    logic        bad;
    begin
      a = pl[0];
      b = pl[1];
      c = pl[2];
      if (a[4:1] > b[4:1]) begin
        t = a; a = b; b = t;
      end
      if (b[4:1] > c[4:1]) begin
        t = b; b = c; c = t;
      end
      if (a[4:1] > b[4:1]) begin
        t = a; a = b; b = t;
      end
      bad = (a[4:1] == b[4:1] && a[0] != b[0]) ||
            (b[4:1] == c[4:1] && b[0] != c[0]);
      p1 = 4'h0;
      p2 = 4'h0;
      i3 = 13'h0000;
      if (a[4:1] == b[4:1] && b[4:1] == c[4:1]) begin
        n  = 2'h1;
        p0 = a[4:1];
        sg = {2'h0, a[0]};
        i1 = `PPI_OFF_N1;
      end else if (a[4:1] == b[4:1]) begin
        n  = 2'h2;
        p0 = a[4:1];
        p1 = c[4:1];
        sg = {1'h0, c[0], a[0]};
        i1 = `PPI_OFF_N2;
      end else if (b[4:1] == c[4:1]) begin
        n  = 2'h2;
        p0 = a[4:1];
        p1 = b[4:1];
        sg = {1'h0, b[0], a[0]};
        i3 = 13'h0001;
        i1 = `PPI_OFF_N2;
      end else begin
        n  = 2'h3;
        p0 = a[4:1];
        p1 = b[4:1];
        p2 = c[4:1];
        sg = {c[0], b[0], a[0]};
        i1 = `PPI_OFF_N3;
      end
      cmn = bin(`PPI_TRK43_LEN, n);
      i2  = cmn - bin(`PPI_TRK43_LEN - {1'h0, p0}, n);
      if (n >= 2'h2) begin
        i2 = i2 + bin(`PPI_TRK43_LEN - {1'h0, p0} - 5'h01, n - 2'h1)
                - bin(`PPI_TRK43_LEN - {1'h0, p1}, n - 2'h1);
      end
      if (n == 2'h3) begin
        i2 = i2 + bin(`PPI_TRK43_LEN - {1'h0, p1} - 5'h01, 2'h1)
                - bin(`PPI_TRK43_LEN - {1'h0, p2}, 2'h1);
      end
      i23 = 13'(i3 * cmn) + i2;
      trk_index = {bad, i1 + (i23 << n) + {10'h000, sg}};
    end
  endfunction : trk_index

  // ----------------------------------------------------------------
  // Single-cycle layouts
  // ----------------------------------------------------------------
  logic [13:0] trk_a, trk_b;
  logic [24:0] joint;

  always_comb begin
    fix_rsp = '0;
    trk_a   = trk_index({{req_r.pos[2][3:0], req_r.neg[2]},
                         {req_r.pos[1][3:0], req_r.neg[1]},
                         {req_r.pos[0][3:0], req_r.neg[0]}});
    trk_b   = trk_index({{req_r.pos[5][3:0], req_r.neg[5]},
                         {req_r.pos[4][3:0], req_r.neg[4]},
                         {req_r.pos[3][3:0], req_r.neg[3]}});
    joint   = 25'(trk_a[12:0]) * 25'(`PPI_TRK43_RANGE) +
              {12'h000, trk_b[12:0]};
    case (req_r.mode)
      ppi_pkg::PPI_MODE_12: begin
        fix_rsp.code[11:0] = {req_r.neg[1], req_r.pos[1][`PPI_M12:1],
                              req_r.neg[0], req_r.pos[0][`PPI_M12:1]};
        fix_rsp.err = req_r.pos[0][0] | ~req_r.pos[1][0];
      end
      ppi_pkg::PPI_MODE_20: begin
        for (int k = 0; k < 4; k++) begin
          fix_rsp.code[k*5 +: 5] = {req_r.neg[k],
                                    req_r.pos[k][`PPI_M20+1:2]};
          if (req_r.pos[k][1:0] != 2'(k)) begin
            fix_rsp.err = 1'b1;
          end
        end
      end
      ppi_pkg::PPI_MODE_43: begin
        fix_rsp.code[`PPI_F43_IDX1_LSB +: 13] = trk_a[12:0];
        fix_rsp.code[`PPI_F43_IDX2_LSB +: 13] = trk_b[12:0];
        fix_rsp.long_joint = (joint >= `PPI_JOINT_LIMIT);
        fix_rsp.code[24:0] = fix_rsp.long_joint ?
                             joint + `PPI_JOINT_LIMIT : joint;
        fix_rsp.err = trk_a[13] | trk_b[13];
      end
      default: begin
        fix_rsp.err = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Enumeration datapath helpers
  // ----------------------------------------------------------------
  always_comb begin
    mag_sum = 8'h00;
    for (int i = 0; i < LEN; i++) begin
      mag_sum = mag_sum + (req_i.data[i*4+3] ?
                {4'h0, 4'h0 - req_i.data[i*4 +: 4]} :
                {4'h0, req_i.data[i*4 +: 4]});
    end
  end

  always_comb begin
    neg_cur = req_r.data[{idx_r, 2'h3}];
    mag_cur = neg_cur ? 4'h0 - req_r.data[{idx_r, 2'h0} +: 4] :
                        req_r.data[{idx_r, 2'h0} +: 4];
    if (req_r.mode == ppi_pkg::PPI_MODE_ENC) begin
      rom_p = rest_r + PW'(mag_cur) - k_r;
    end else begin
      rom_p = rest_r - k_r;
    end
    rom_len = LW'(LEN - 1) - LW'(idx_r);
    // count products, length-one counts are 1 or 2
    term = (k_r == '0) ? rom_data : rom_data << 1;
  end

  ppi_count_rom #(
    .PMAX (PMAX),
    .LMAX (LEN),
    .W    (CW)
  ) u_rom (
    .core_clk_i (core_clk_i),
    .rd_p_i     (rom_p),
    .rd_len_i   (rom_len),
    .rd_data_o  (rom_data)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ppi_pkg::PPI_S_IDLE: begin
        if (start_i) begin
          if (req_i.mode == ppi_pkg::PPI_MODE_ENC) begin
            state_nxt = (mag_sum > 8'(PMAX)) ? ppi_pkg::PPI_S_IDLE :
                                               ppi_pkg::PPI_S_POS;
          end else if (req_i.mode == ppi_pkg::PPI_MODE_DEC) begin
            state_nxt = (int'(req_i.pulses) > PMAX) ? ppi_pkg::PPI_S_IDLE :
                                                      ppi_pkg::PPI_S_POS;
          end else begin
            state_nxt = ppi_pkg::PPI_S_FIX;
          end
        end
      end
      ppi_pkg::PPI_S_FIX: state_nxt = ppi_pkg::PPI_S_IDLE;
      ppi_pkg::PPI_S_POS: begin
        if (req_r.mode == ppi_pkg::PPI_MODE_ENC) begin
          state_nxt = (mag_cur == 4'h0) ? ppi_pkg::PPI_S_ADV :
                                          ppi_pkg::PPI_S_TERM;
        end else if (int'(idx_r) == LEN - 1) begin
          state_nxt = ppi_pkg::PPI_S_IDLE;
        end else begin
          state_nxt = (rest_r == '0) ? ppi_pkg::PPI_S_ADV :
                                       ppi_pkg::PPI_S_TERM;
        end
      end
      ppi_pkg::PPI_S_TERM: state_nxt = ppi_pkg::PPI_S_ACC;
      ppi_pkg::PPI_S_ACC: begin
        if (req_r.mode == ppi_pkg::PPI_MODE_ENC) begin
          state_nxt = (PW'(mag_cur) == k_r + 1'b1) ? ppi_pkg::PPI_S_ADV :
                                                    ppi_pkg::PPI_S_TERM;
        end else if (acc_r < off_r + term || k_r + 1'b1 == rest_r) begin
          state_nxt = ppi_pkg::PPI_S_ADV;
        end else begin
          state_nxt = ppi_pkg::PPI_S_TERM;
        end
      end
      ppi_pkg::PPI_S_ADV: begin
        if (req_r.mode == ppi_pkg::PPI_MODE_ENC && idx_r == '0) begin
          state_nxt = ppi_pkg::PPI_S_IDLE;
        end else begin
          state_nxt = ppi_pkg::PPI_S_POS;
        end
      end
      default: state_nxt = ppi_pkg::PPI_S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= ppi_pkg::PPI_S_IDLE;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r  <= (state_nxt != ppi_pkg::PPI_S_IDLE);
    end
  end

  // one-cycle done when the result lands
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (state_r != ppi_pkg::PPI_S_IDLE || start_i) &&
                state_nxt == ppi_pkg::PPI_S_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Enumeration walk, one position per pass
  // ----------------------------------------------------------------
  // sequential walk
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_r     <= '0;
      idx_r     <= '0;
      rest_r    <= '0;
      k_r       <= '0;
      acc_r     <= '0;
      off_r     <= '0;
      dec_vec_r <= '0;
    end else begin
      case (state_r)
        ppi_pkg::PPI_S_IDLE: begin
          if (start_i) begin
            req_r     <= req_i;
            dec_vec_r <= '0;
            if (req_i.mode == ppi_pkg::PPI_MODE_ENC) begin
              // Last position is a leaf: its state is just its sign
              // leaf state
              idx_r  <= IW'(LEN - 2);
              rest_r <= PW'(req_i.data[(LEN-1)*4 +: 4] ^
                            {4{req_i.data[LEN*4-1]}}) +
                        PW'(req_i.data[LEN*4-1]);
              acc_r  <= CW'(req_i.data[LEN*4-1]);
            end else begin
              idx_r  <= '0;
              rest_r <= PW'(req_i.pulses);
              acc_r  <= req_i.data;
            end
          end
        end
        ppi_pkg::PPI_S_POS: begin
          off_r <= '0;
          k_r   <= '0;
          if (req_r.mode == ppi_pkg::PPI_MODE_DEC &&
              int'(idx_r) == LEN - 1) begin
            dec_vec_r[idx_r] <= acc_r[0] ? 4'h0 - 4'(rest_r) : 4'(rest_r);
          end
        end
        ppi_pkg::PPI_S_ACC: begin
          if (req_r.mode == ppi_pkg::PPI_MODE_ENC) begin
            off_r <= off_r + term;
            k_r   <= k_r + 1'b1;
          end else if (!(acc_r < off_r + term)) begin
            off_r <= off_r + term;
            k_r   <= k_r + 1'b1;
          end
        end
        ppi_pkg::PPI_S_ADV: begin
          if (req_r.mode == ppi_pkg::PPI_MODE_ENC) begin
            acc_r  <= off_r + CW'(neg_cur && mag_cur != 4'h0) +
                      ((mag_cur != 4'h0) ? acc_r << 1 : acc_r);
            rest_r <= rest_r + PW'(mag_cur);
            idx_r  <= idx_r - 1'b1;
          end else begin
            dec_vec_r[idx_r] <= ((k_r != '0) && acc_r[0] != off_r[0]) ?
                                4'h0 - 4'(k_r) : 4'(k_r);
            acc_r  <= (k_r != '0) ? (acc_r - off_r) >> 1 : acc_r - off_r;
            rest_r <= rest_r - k_r;
            idx_r  <= idx_r + 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rsp_r <= '0;
    end else if (state_r == ppi_pkg::PPI_S_IDLE && start_i &&
                 state_nxt == ppi_pkg::PPI_S_IDLE) begin
      rsp_r <= '{code: 64'h0, long_joint: 1'b0, err: 1'b1};
    end else if (state_r == ppi_pkg::PPI_S_FIX) begin
      rsp_r <= fix_rsp;
    end else if (state_r == ppi_pkg::PPI_S_ADV &&
                 state_nxt == ppi_pkg::PPI_S_IDLE) begin
      rsp_r <= '{code: off_r + CW'(neg_cur && mag_cur != 4'h0) +
                       ((mag_cur != 4'h0) ? acc_r << 1 : acc_r),
                 long_joint: 1'b0, err: 1'b0};
    end else if (state_r == ppi_pkg::PPI_S_POS &&
                 state_nxt == ppi_pkg::PPI_S_IDLE) begin
      // Leaf is the last position, so it fills the top nibble
      rsp_r <= '{code: {acc_r[0] ? 4'h0 - 4'(rest_r) : 4'(rest_r),
                        dec_vec_r[LEN-2:0]},
                 long_joint: 1'b0, err: 1'b0};
    end
  end

  assign done_o = done_r;
  assign busy_o = busy_r;
  assign rsp_o  = rsp_r;

endmodule : ppi_top

/* File: verif/ppi_packer_model.sv */
module ppi_packer_model (
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              done_i,
  input  wire ppi_pkg::ppi_rsp_t rsp_i,
  output ppi_pkg::ppi_rsp_t      word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // take on done
  // Result is only trusted in the done cycle, so latch it there
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      word_o <= '0;
    end else if (done_i) begin
      word_o <= rsp_i;
    end
  end
endmodule : ppi_packer_model

/* File: verif/ppi_top_props.sv */
`include "ppi_defines.svh"

module ppi_top_props (
  input wire logic              core_clk_i,
  input wire logic              sys_rst_i,
  input wire logic              start_i,
  input wire ppi_pkg::ppi_req_t req_i,
  input wire logic              done_o,
  input wire logic              busy_o,
  input wire ppi_pkg::ppi_rsp_t rsp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  ppi_pkg::ppi_req_t cap_r;
  logic [31:0]       jnt;
  logic              m12;
  logic              m20;
  logic              m43;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Idle starts only; a start while busy is ignored by the block too
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cap_r <= '0;
    end else if (start_i && !busy_o) begin
      cap_r <= req_i;
    end
  end

  assign jnt = 32'(rsp_o.code[37:25]) * 32'(`PPI_TRK43_RANGE)
             + 32'(rsp_o.code[50:38]);
  assign m12 = done_o && cap_r.mode == ppi_pkg::PPI_MODE_12;
  assign m20 = done_o && cap_r.mode == ppi_pkg::PPI_MODE_20 && !rsp_o.err;
  assign m43 = done_o && cap_r.mode == ppi_pkg::PPI_MODE_43 && !rsp_o.err;

  sequence s_take12;
    start_i && !busy_o && req_i.mode == ppi_pkg::PPI_MODE_12
      && !req_i.pos[0][0] && req_i.pos[1][0];
  endsequence
  sequence s_answer;
    busy_o && !done_o ##1 done_o && !busy_o;
  endsequence

  a_fix_latency: assert property (s_take12 |=> s_answer)
    else $error("fixed layout answer not two cycles after take");
  a_done_pulse: assert property (
    done_o && !(start_i && !busy_o) |=> !done_o)
    else $error("done held longer than one cycle");
  a_done_idle: assert property (done_o |-> !busy_o)
    else $error("busy still high with done");
  a_busy_bound: assert property (
    $rose(busy_o) |-> ##[0:300] ($fell(busy_o) && done_o))
    else $error("request did not finish in time");
  a_trk12_code: assert property (m12 && !rsp_o.err |->
    rsp_o.code[11:0] == {cap_r.neg[1], cap_r.pos[1][5:1],
                         cap_r.neg[0], cap_r.pos[0][5:1]})
    else $error("two-track code wrong");
  a_trk12_err: assert property (m12 |->
    rsp_o.err == (cap_r.pos[0][0] || !cap_r.pos[1][0]))
    else $error("two-track parity flag wrong");
  a_trk20_code: assert property (m20 |->
    rsp_o.code[19:0] == {cap_r.neg[3], cap_r.pos[3][5:2],
      cap_r.neg[2], cap_r.pos[2][5:2], cap_r.neg[1],
      cap_r.pos[1][5:2], cap_r.neg[0], cap_r.pos[0][5:2]})
    else $error("four-track code wrong");
  a_joint_split: assert property (m43 |->
    rsp_o.long_joint == (rsp_o.code[24:0] >= `PPI_JOINT_LIMIT)
    && 32'(rsp_o.code[24:0]) == jnt
       + (rsp_o.long_joint ? 32'(`PPI_JOINT_LIMIT) : 32'h0))
    else $error("joint index split wrong");
endmodule : ppi_top_props

bind ppi_top ppi_top_props u_props (
  .core_clk_i (core_clk_i),
  .sys_rst_i  (sys_rst_i),
  .start_i    (start_i),
  .req_i      (req_i),
  .done_o     (done_o),
  .busy_o     (busy_o),
  .rsp_o      (rsp_o)
);

/* File: verif/pulse_position_indexer_tb.sv */
`include "ppi_defines.svh"

module pulse_position_indexer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic              core_clk_i = 1'b0;
  logic              sys_rst_i  = 1'b1;
  logic              start_i    = 1'b0;
  ppi_pkg::ppi_req_t req_i      = '0;
  ppi_pkg::ppi_req_t r;
  ppi_pkg::ppi_rsp_t rsp_o;
  ppi_pkg::ppi_rsp_t got;
  logic              done_o;
  logic              busy_o;
  logic [63:0]       fl [0:8][1:16];
  int                n_errors = 0;
  int                checked  = 0;

  always #10 core_clk_i = ~core_clk_i;

  ppi_top dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .start_i(start_i), .req_i(req_i), .done_o(done_o),
    .busy_o(busy_o), .rsp_o(rsp_o));
  ppi_packer_model pk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .done_i(done_o), .rsp_i(rsp_o), .word_o(got));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("errors %0d checked %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Request stays on req_i until the next one, keeping it stable
  task automatic run();
    int i;
    @(negedge core_clk_i);
    start_i = 1'b1;
    req_i = r;
    @(negedge core_clk_i);
    start_i = 1'b0;
    for (i = 0; i < 400 && done_o !== 1'b1; i++) begin
      @(negedge core_clk_i);
    end
    if (i == 400) begin
      n_errors++;
      $display("FAIL %0t no done", $time);
      test_done();
    end
    @(negedge core_clk_i);
  endtask : run

  function automatic int bin(input int n, input int k);
    int i;
    int v;
    v = 1;
    for (i = 0; i < k; i++) begin
      v = v * (n - i) / (i + 1);
    end
    return v;
  endfunction : bin

  function automatic logic [12:0] ind3(input int a, input int b,
                                       input int c, input int s);
    return 13'((bin(16, 3) - bin(16 - a, 3) + bin(15 - a, 2)
      - bin(16 - b, 2) + bin(15 - b, 1) - bin(16 - c, 1)) * 8 + s);
  endfunction : ind3

  // One position at a time, walking back from the last one
  function automatic logic [63:0] enc(input logic [63:0] d);
    logic [63:0] st;
    logic [63:0] off;
    int          i;
    int          q;
    int          a;
    int          pp;
    st = 64'h0;
    pp = 0;
    for (i = 15; i >= 0; i--) begin
      a = int'($signed(d[4*i +: 4]));
      st = (i == 15) ? 64'(a < 0) : st;
      a = (a < 0) ? -a : a;
      pp += a;
      off = 64'h0;
      for (q = 0; q < a && i < 15; q++) begin
        off += fl[q][1] * fl[pp - q][15 - i];
      end
      if (i < 15) begin
        st = off + 64'(d[4*i+3] && a > 0) + ((a > 0) ? 64'h2 : 64'h1) * st;
      end
    end
    return st;
  endfunction : enc

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_fixed();
    int k;
    logic [5:0] a;
    logic [5:0] b;
    logic [4:0] p;
    r = '0;
    for (k = 0; k < 4; k++) begin
      a = 6'(k * 22);
      b = 6'(63 - k * 20);
      r.mode = ppi_pkg::PPI_MODE_12;
      r.pos[1:0] = {b, a};
      r.neg[1:0] = 2'(k);
      run();
      chk(64'(got.err), 64'h0);
      chk(64'(got.code[11:0]), 64'({r.neg[1], b[5:1], r.neg[0], a[5:1]}));
      r.mode = ppi_pkg::PPI_MODE_20;
      p = 5'(k * 5);
      r.pos[3:0] = {6'(4 * p + 3), 6'(4 * p + 2), 6'(4 * p + 1), 6'(4 * p)};
      r.neg[3:0] = 4'(k * 5);
      run();
      chk(64'(got.code[19:0]), 64'({r.neg[3], p[3:0], r.neg[2], p[3:0],
        r.neg[1], p[3:0], r.neg[0], p[3:0]}));
    end
    r.pos[2] = 6'h01;
    run();
    chk(64'(got.err), 64'h1);
    r.mode = ppi_pkg::PPI_MODE_12;
    r.pos[0] = 6'h01;
    run();
    chk(64'(got.err), 64'h1);
  endtask : t_fixed

  task automatic t_enum(input logic [63:0] d, input logic [3:0] np,
                        input logic e);
    r = '0;
    r.mode = ppi_pkg::PPI_MODE_ENC;
    r.data = d;
    run();
    chk(64'(got.err), 64'(e));
    if (!e) begin
      chk(got.code, enc(d));
      r.mode = ppi_pkg::PPI_MODE_DEC;
      r.data = enc(d);
      r.pulses = np;
      run();
      chk(got.code, d);
    end
  endtask : t_enum

  task automatic t_joint(input logic [35:0] p, input logic [5:0] n,
                         input logic [12:0] ia, input logic [12:0] ib,
                         input logic e);
    logic [31:0] j;
    r = '0;
    r.mode = ppi_pkg::PPI_MODE_43;
    r.pos = p;
    r.neg = n;
    run();
    chk(64'(got.err), 64'(e));
    j = 32'(ia) * 32'(`PPI_TRK43_RANGE) + 32'(ib);
    if (!e) begin
      chk(64'(got.long_joint), 64'(j >= 32'(`PPI_JOINT_LIMIT)));
      chk(64'(got.code[50:0]), {13'h0, ib, ia, 25'((j >= 32'(
        `PPI_JOINT_LIMIT)) ? j + 32'(`PPI_JOINT_LIMIT) : j)});
    end
  endtask : t_joint

  initial begin
    for (int p = 0; p <= 8; p++) begin
      for (int l = 1; l <= 16; l++) begin
        fl[p][l] = (p == 0) ? 64'h1 : 64'h2;
        for (int q = 0; q <= p && l > 1; q++) begin
          fl[p][l] = (q == 0) ? 64'h0 : fl[p][l];
          fl[p][l] += ((q == 0) ? 64'h1 : 64'h2) * fl[p - q][l - 1];
        end
      end
    end
    repeat (20) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    chk({61'h0, done_o, busy_o, |rsp_o}, 64'h0);
    t_fixed();
    t_enum(64'h0, 4'h0, 1'b0);
    t_enum(64'h0000_0000_0000_000F, 4'h1, 1'b0);
    t_enum(64'h2000_0F00_E010_1001, 4'h8, 1'b0);
    t_enum(64'h8000_0000_0000_0000, 4'h8, 1'b0);
    t_enum(64'h0000_0000_0000_0099, 4'h0, 1'b1);
    r.mode = ppi_pkg::PPI_MODE_DEC;
    r.pulses = 4'h9;
    run();
    chk(got.code, 64'h0);
    chk(64'(got.err), 64'h1);
    r.mode = ppi_pkg::ppi_mode_t'(3'h5);
    run();
    chk(64'(got.err), 64'h1);
    t_joint({6'h0D, 6'h0E, 6'h0F, 6'h02, 6'h01, 6'h00}, 6'h3A,
      ind3(0, 1, 2, 2), ind3(13, 14, 15, 7), 1'b0);
    t_joint({6'h0D, 6'h0E, 6'h0F, 6'h0D, 6'h0E, 6'h0F}, 6'h3F,
      ind3(13, 14, 15, 7), ind3(13, 14, 15, 7), 1'b0);
    t_joint({6'h02, 6'h01, 6'h00, 6'h09, 6'h03, 6'h03}, 6'h00,
      `PPI_OFF_N2 + 13'((bin(16, 2) - bin(13, 2) + bin(12, 1)
      - bin(7, 1)) * 4), ind3(0, 1, 2, 0), 1'b0);
    t_joint({6'h02, 6'h01, 6'h00, 6'h07, 6'h05, 6'h05}, 6'h02,
      13'h0, 13'h0, 1'b1);
    test_done();
  end
endmodule : pulse_position_indexer_tb
